// File: hw/fdd_pin_pkg.sv
// Constants and carrier types for the floppy drive pin interface.
// Summary of operation
// - The head-travel-sense output is high for outward motion and low for inward motion toward the spindle.
// - Each one-track head move produces one active-low pulse on the track-move output.
// - The side-select output is high for head side 0 and low for head side 1.
// - The spindle-motor-A output is pulled low to run the motor of drive 0 and released otherwise.
// - The unit-A-select output is pulled low while drive A is selected and released otherwise.
// - Serial write data leaves active low on the write-serial output, without precompensation.
// - The density-selection output carries bit 0 of the drive density code.
// - Serial read data arrives active low on the read-serial input.
// - Bit 7 of the pull-up configuration register enables the input pull-ups, which are off after reset.
// - The reference clock is 24MHz or 48MHz by configuration, with 48MHz by default.
package fdd_pin_pkg;

    // ------------------------------------------------------------------
    // Configuration and timing
    // ------------------------------------------------------------------
    localparam int         PULLUP_BIT       = 7;
    localparam logic [7:0] PULLUP_CFG_RST   = 8'h00;
    localparam logic       REF_CLK_48_RST   = 1'b1;
    localparam int         CLK_MHZ          = 100;
    localparam int         STEP_PULSE_NS    = 3000;
    localparam int         STEP_PULSE_CYC   = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int         STEP_CNT_W       = 16;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // State names differ from the step timing parameters, which would otherwise hide them.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PULSE = 2'b01,
        ST_GAP   = 2'b10
    } step_state_t;

    typedef struct packed {
        logic motor_a;
        logic select_a;
        logic dir_out;
        logic side1;
        logic write_en;
        logic write_bit;
        logic density_lsb;
    } drive_ctrl_t;

    typedef struct packed {
        logic index_mark;
        logic track_zero;
        logic write_prot;
        logic read_bit;
        logic media_changed;
    } drive_stat_t;

endpackage

// File: hw/od_pin.sv
// Open-drain output pin: pulls low while asserted, floats otherwise.
`timescale 1ns/1ps
module od_pin (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // Function
    input  wire logic assert_in,
    // Pin
    output logic      pin_out,
    output logic      pin_oe_out
);
    logic oe_ff;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= assert_in;
        end
    end

    assign pin_out    = 1'b0;
    assign pin_oe_out = oe_ff;
endmodule // od_pin

// File: hw/fdd_pin_if.sv
// Drive-side pin logic of the floppy controller.
`timescale 1ns/1ps
module fdd_pin_if
    import fdd_pin_pkg::*;
#(
    parameter int STEP_PULSE = fdd_pin_pkg::STEP_PULSE_CYC,
    parameter int STEP_GAP   = fdd_pin_pkg::STEP_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                      clock_in,
    input  wire logic                      rst_in,
    // Core side
    input  wire fdd_pin_pkg::drive_ctrl_t  ctrl_in,
    input  wire logic                      step_req_in,
    input  wire logic                      pullup_wr_in,
    input  wire logic [7:0]                pullup_wdata_in,
    input  wire logic                      ref_clk_wr_in,
    input  wire logic                      ref_clk_48_in,
    output fdd_pin_pkg::drive_stat_t       stat_out,
    output logic                           step_busy_out,
    output logic                           home_out,
    output logic                           write_inhibit_out,
    output logic [7:0]                     pullup_cfg_out,
    output logic                           ref_clk_48_out,
    // Drive pins, open drain
    output logic                           density_sel_lsb_out,
    output logic                           density_sel_lsb_oe_out,
    output logic                           spindle_motor_a_n_out,
    output logic                           spindle_motor_a_n_oe_out,
    output logic                           unit_a_select_n_out,
    output logic                           unit_a_select_n_oe_out,
    output logic                           head_dir_out,
    output logic                           head_dir_oe_out,
    output logic                           track_move_n_out,
    output logic                           track_move_n_oe_out,
    output logic                           write_serial_n_out,
    output logic                           write_serial_n_oe_out,
    output logic                           write_gate_n_out,
    output logic                           write_gate_n_oe_out,
    output logic                           side_sel_out,
    output logic                           side_sel_oe_out,
    // Drive status pins
    input  wire logic                      rev_mark_n_in,
    input  wire logic                      outer_track_n_in,
    input  wire logic                      media_protect_n_in,
    input  wire logic                      read_serial_n_in,
    input  wire logic                      media_changed_n_in,
    output logic                           pullup_en_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int NPIN = 8;

    typedef struct packed {
        step_state_t             step_st;
        logic [STEP_CNT_W-1:0]   step_cnt;
        logic [NPIN-1:0]         low_req;
        drive_stat_t             stat;
        logic [7:0]              pullup_cfg;
        logic                    ref48;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic   inhibit;

    assign inhibit = state_ff.stat.write_prot;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.stat.index_mark    = ~rev_mark_n_in;
        nxt_state.stat.track_zero    = ~outer_track_n_in;
        nxt_state.stat.write_prot    = ~media_protect_n_in;
        nxt_state.stat.read_bit      = ~read_serial_n_in;
        nxt_state.stat.media_changed = ~media_changed_n_in;
        if (pullup_wr_in) begin
            nxt_state.pullup_cfg = pullup_wdata_in;
        end
        if (ref_clk_wr_in) begin
            nxt_state.ref48 = ref_clk_48_in;
        end
        // A new step is not taken until the gap after the last pulse ends.
        case (state_ff.step_st)
            ST_IDLE: begin
                if (step_req_in) begin
                    nxt_state.step_st  = ST_PULSE;
                    nxt_state.step_cnt = STEP_CNT_W'(STEP_PULSE - 1);
                end
            end
            ST_PULSE: begin
                if (state_ff.step_cnt == '0) begin
                    nxt_state.step_st  = ST_GAP;
                    nxt_state.step_cnt = STEP_CNT_W'(STEP_GAP - 1);
                end else begin
                    nxt_state.step_cnt = state_ff.step_cnt - 1'b1;
                end
            end
            ST_GAP: begin
                if (state_ff.step_cnt == '0) begin
                    nxt_state.step_st = ST_IDLE;
                end else begin
                    nxt_state.step_cnt = state_ff.step_cnt - 1'b1;
                end
            end
            default: begin
                nxt_state.step_st = ST_IDLE;
            end
        endcase
        // Pins low means asserted; polarity folded per pin here.
        nxt_state.low_req[0] = ~ctrl_in.density_lsb;
        nxt_state.low_req[1] = ctrl_in.motor_a;
        nxt_state.low_req[2] = ctrl_in.select_a;
        nxt_state.low_req[3] = ~ctrl_in.dir_out;
        nxt_state.low_req[4] = (nxt_state.step_st == ST_PULSE);
        nxt_state.low_req[5] = ctrl_in.write_en & ~inhibit & ctrl_in.write_bit;
        nxt_state.low_req[6] = ctrl_in.write_en & ~inhibit;
        nxt_state.low_req[7] = ctrl_in.side1;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff            <= '0;
            state_ff.step_st    <= ST_IDLE;
            state_ff.pullup_cfg <= PULLUP_CFG_RST;
            state_ff.ref48      <= REF_CLK_48_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Open-drain pins
    // ------------------------------------------------------------------
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_oe;

    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_pin
            od_pin u_pin (
                .clock_in   (clock_in),
                .rst_in     (rst_in),
                .assert_in  (state_ff.low_req[i]),
                .pin_out    (pin_lvl[i]),
                .pin_oe_out (pin_oe[i])
            );
        end
    endgenerate

    assign density_sel_lsb_out      = pin_lvl[0];
    assign density_sel_lsb_oe_out   = pin_oe[0];
    assign spindle_motor_a_n_out    = pin_lvl[1];
    assign spindle_motor_a_n_oe_out = pin_oe[1];
    assign unit_a_select_n_out      = pin_lvl[2];
    assign unit_a_select_n_oe_out   = pin_oe[2];
    assign head_dir_out             = pin_lvl[3];
    assign head_dir_oe_out          = pin_oe[3];
    assign track_move_n_out         = pin_lvl[4];
    assign track_move_n_oe_out      = pin_oe[4];
    assign write_serial_n_out       = pin_lvl[5];
    assign write_serial_n_oe_out    = pin_oe[5];
    assign write_gate_n_out         = pin_lvl[6];
    assign write_gate_n_oe_out      = pin_oe[6];
    assign side_sel_out             = pin_lvl[7];
    assign side_sel_oe_out          = pin_oe[7];

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    assign stat_out          = state_ff.stat;
    assign step_busy_out     = (state_ff.step_st != ST_IDLE);
    assign home_out          = state_ff.stat.track_zero;
    assign write_inhibit_out = state_ff.stat.write_prot;
    assign pullup_cfg_out    = state_ff.pullup_cfg;
    assign pullup_en_out     = state_ff.pullup_cfg[PULLUP_BIT];
    assign ref_clk_48_out    = state_ff.ref48;
endmodule // fdd_pin_if

// File: testbench/fdd_drive_model.sv
// Behavioural floppy drive at the far end of the cable.
`timescale 1ns/1ps
module fdd_drive_model (
    input  wire logic clock_in,
    input  wire logic step_n_in,
    input  wire logic dir_in,
    input  wire logic motor_n_in,
    input  wire logic sel_n_in,
    input  wire logic prot_in,
    input  wire logic disk_in,
    input  wire logic data_in,
    output logic      rev_mark_n_out,
    output logic      outer_track_n_out,
    output logic      media_protect_n_out,
    output logic      read_serial_n_out,
    output logic      media_changed_n_out
);
    int         track  = 2;
    logic [3:0] angle  = 4'h0;
    logic       step_q = 1'b1;
    always @(posedge clock_in) begin
        step_q <= step_n_in;
        if (!step_q && step_n_in) track <= dir_in ? track - 1 : track + 1;
        if (!motor_n_in) angle <= angle + 4'h1;
    end
    // A deselected drive lets its lines float up to the cable pull-up.
    assign rev_mark_n_out      = sel_n_in | motor_n_in | (angle > 4'h1);
    assign outer_track_n_out   = sel_n_in | (track != 0);
    assign media_protect_n_out = sel_n_in | !prot_in;
    assign read_serial_n_out   = sel_n_in | !data_in;
    assign media_changed_n_out = sel_n_in | disk_in;
endmodule // fdd_drive_model

// File: testbench/fdd_pin_if_monitor.sv
// Assertion checker for the floppy drive pins.
`timescale 1ns/1ps
module fdd_pin_if_monitor
    import fdd_pin_pkg::*;
#(parameter int STEP_PULSE = 2) (
    input wire logic                     clock_in,
    input wire logic                     rst_in,
    input wire fdd_pin_pkg::drive_ctrl_t ctrl_in,
    input wire logic                     step_req_in,
    input wire logic                     step_busy_out,
    input wire logic                     track_move_n_oe_out,
    input wire logic                     spindle_motor_a_n_oe_out,
    input wire logic                     unit_a_select_n_oe_out,
    input wire logic                     head_dir_oe_out,
    input wire logic                     side_sel_oe_out,
    input wire logic                     density_sel_lsb_oe_out,
    input wire logic                     write_serial_n_oe_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Pins lag their controls by two edges, so early edges after reset see stale history.
    logic [1:0] up_ff;
    always_ff @(posedge clock_in or posedge rst_in)
        if (rst_in) up_ff <= 2'h0;
        else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
    wire settled = (up_ff == 2'h3);
    sequence s_start; step_busy_out ##1 track_move_n_oe_out; endsequence
    property p_motor; settled |-> spindle_motor_a_n_oe_out == $past(ctrl_in.motor_a, 2); endproperty
    a_motor: assert property (p_motor) else $error("motor pin wrong");
    property p_select; settled |-> unit_a_select_n_oe_out == $past(ctrl_in.select_a, 2); endproperty
    a_select: assert property (p_select) else $error("select pin wrong");
    property p_dir; settled |-> head_dir_oe_out == !$past(ctrl_in.dir_out, 2); endproperty
    a_dir: assert property (p_dir) else $error("direction pin wrong");
    property p_side; settled |-> side_sel_oe_out == $past(ctrl_in.side1, 2); endproperty
    a_side: assert property (p_side) else $error("side pin wrong");
    property p_density; settled |-> density_sel_lsb_oe_out == !$past(ctrl_in.density_lsb, 2); endproperty
    a_density: assert property (p_density) else $error("density pin wrong");
    property p_wdata; write_serial_n_oe_out |-> $past(ctrl_in.write_bit, 2); endproperty
    a_wdata: assert property (p_wdata) else $error("write data pin wrong");
    property p_step; step_req_in && !step_busy_out |=> s_start; endproperty
    a_step: assert property (p_step) else $error("step pulse missing");
    property p_width;
        $fell(track_move_n_oe_out) |-> $past(track_move_n_oe_out, STEP_PULSE) && !$past(track_move_n_oe_out, STEP_PULSE + 1);
    endproperty
    a_width: assert property (p_width) else $error("step pulse width wrong");
endmodule // fdd_pin_if_monitor
bind fdd_pin_if fdd_pin_if_monitor #(.STEP_PULSE(STEP_PULSE)) i_monitor (.*);

// File: testbench/floppy_drive_pin_interface_tb.sv
// Self-checking bench for the floppy drive pin interface.
`timescale 1ns/1ps
module floppy_drive_pin_interface_tb;
    import fdd_pin_pkg::*;
    typedef struct { int due; logic [4:0] val; } note_t;
    logic        clock_in = 0, rst_in = 1, step_req_in = 0, pullup_wr_in = 0, ref_clk_wr_in = 0;
    logic        ref_clk_48_in = 1, prot = 0, disk = 0, data = 0, idx_seen = 0;
    logic        step_busy_out, home_out, write_inhibit_out, ref_clk_48_out, pullup_en_out;
    logic        rev_mark_n_in, outer_track_n_in, media_protect_n_in, read_serial_n_in, media_changed_n_in;
    logic [7:0]  pullup_wdata_in = 8'h00, pullup_cfg_out, o, oe;
    logic [31:0] seed = 32'h26d4_2af4;
    drive_ctrl_t ctrl_in = '0;
    drive_stat_t stat_out;
    note_t       notes[$];
    int          mismatches = 0, check_count = 0, cyc = 0, pulses = 0;
    wire [7:0]   pin = ~oe | o;
    fdd_pin_if #(.STEP_PULSE(2), .STEP_GAP(2)) i_dut (.*,
        .density_sel_lsb_out(o[7]), .density_sel_lsb_oe_out(oe[7]), .spindle_motor_a_n_out(o[6]),
        .spindle_motor_a_n_oe_out(oe[6]), .unit_a_select_n_out(o[5]), .unit_a_select_n_oe_out(oe[5]),
        .head_dir_out(o[4]), .head_dir_oe_out(oe[4]), .track_move_n_out(o[3]), .track_move_n_oe_out(oe[3]),
        .write_serial_n_out(o[2]), .write_serial_n_oe_out(oe[2]), .write_gate_n_out(o[1]),
        .write_gate_n_oe_out(oe[1]), .side_sel_out(o[0]), .side_sel_oe_out(oe[0]));
    fdd_drive_model i_drive (.clock_in(clock_in), .step_n_in(pin[3]), .dir_in(pin[4]), .motor_n_in(pin[6]),
        .sel_n_in(pin[5]), .prot_in(prot), .disk_in(disk), .data_in(data), .rev_mark_n_out(rev_mark_n_in),
        .outer_track_n_out(outer_track_n_in), .media_protect_n_out(media_protect_n_in),
        .read_serial_n_out(read_serial_n_in), .media_changed_n_out(media_changed_n_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic expect_pins();
        notes.push_back('{cyc + 2, {!ctrl_in.density_lsb, ctrl_in.motor_a, ctrl_in.select_a, !ctrl_in.dir_out,
            ctrl_in.side1}});
    endtask
    // The second request cycle lands while busy, so it must not start another pulse.
    task automatic step_once(input logic outward);
        ctrl_in.dir_out = outward;
        tick(3);
        step_req_in = 1;
        tick(2);
        step_req_in = 0;
        for (int i = 0; i < 50 && step_busy_out; i++) tick(1);
        tick(1);
    endtask
    initial forever #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc++;
        if (stat_out.index_mark === 1'b1) idx_seen = 1;
    end
    always @(posedge oe[3]) pulses++;
    always @(negedge clock_in) begin
        if (notes.size() > 0 && notes[0].due <= cyc) begin
            chk({3'h0, oe[7:4], oe[0]}, {3'h0, notes[0].val});
            void'(notes.pop_front());
        end
    end
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
    initial begin
        tick(2);
        rst_in = 0;
        chk(pullup_cfg_out, 8'h00);
        chk({7'h00, ref_clk_48_out}, 8'h01);
        chk(oe, 8'h00);
        chk(o, 8'h00);
        repeat (40) begin
            seed = xs(seed);
            ctrl_in = seed[6:0];
            data = seed[9];
            expect_pins();
            tick(1);
        end
        ctrl_in = '0;
        data = 0;
        ctrl_in.motor_a = 1;
        ctrl_in.select_a = 1;
        expect_pins();
        tick(20);
        chk({4'h0, stat_out[3:0]}, 8'h01);
        chk({7'h00, idx_seen}, 8'h01);
        {prot, disk, data} = 3'b111;
        ctrl_in.write_en = 1;
        ctrl_in.write_bit = 1;
        tick(6);
        chk({stat_out[3:0], write_inhibit_out, oe[2], oe[1], 1'b0}, 8'h68);
        prot = 0;
        tick(6);
        chk({6'h00, oe[2], oe[1]}, 8'h03);
        ctrl_in.write_en = 0;
        step_once(1);
        step_once(1);
        tick(4);
        chk({6'h00, stat_out.track_zero, home_out}, 8'h03);
        step_once(0);
        tick(4);
        chk(pulses[7:0], 8'h03);
        chk({6'h00, stat_out.track_zero, home_out}, 8'h00);
        for (int i = 0; i < 2; i++) begin
            pullup_wdata_in = i ? 8'h7f : 8'h80;
            pullup_wr_in = 1;
            tick(1);
            pullup_wr_in = 0;
            tick(2);
            chk(pullup_cfg_out, pullup_wdata_in);
            chk({7'h00, pullup_en_out}, {7'h00, pullup_wdata_in[7]});
        end
        ref_clk_48_in = 0;
        ref_clk_wr_in = 1;
        tick(1);
        ref_clk_wr_in = 0;
        tick(2);
        chk({7'h00, ref_clk_48_out}, 8'h00);
        final_report();
    end
endmodule // floppy_drive_pin_interface_tb
